// ==== hw/lvpps_edge_sync.sv ====
// Synchroniser and rising edge finder for the incoming shift clock.
`default_nettype none
module lvpps_edge_sync (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic asyncIn,
  output logic level,
  output logic rise
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= asyncIn;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise = sync_q & ~last_q;
endmodule
`default_nettype wire

// ==== hw/lvpps_packer.sv ====
// Packet layout for single and stereo packets.
`default_nettype none
module lvpps_packer (
  input wire logic [lvpps_pkg::PIX_W-1:0] pri,
  input wire logic [lvpps_pkg::PIX_W-1:0] sec,
  input wire logic line,
  input wire logic frame,
  input wire logic wide,
  input wire logic stereo,
  output logic [lvpps_pkg::PKT_W-1:0] pkt,
  output logic [lvpps_pkg::IDX_W-1:0] lastIdx
);
  import lvpps_pkg::*;
  wire [PKT_W-1:0] pkt8 = {6'h00, 1'b0, frame, line, pri[9:2], 1'b1};
  wire [PKT_W-1:0] pkt10 = {6'h00, 1'b0, pri, 1'b1};
  wire [PKT_W-1:0] pktSt = {1'b0, sec[9:2], pri[9:2], 1'b1};

  assign pkt = stereo ? pktSt : (wide ? pkt10 : pkt8);
  assign lastIdx = stereo ? LAST_STEREO : LAST_SINGLE;
endmodule
`default_nettype wire

// ==== hw/lvpps_serializer.sv ====
// Pixel packet serializer with framing codes and register slave.
// Operation
// - Single mode sends twelve bit packets.
// - Eight bit layout: start, pixel, flags, stop.
// - Ten bit layout: start, pixel, stop.
// - Stereo mode sends eighteen bit packets.
// - Stereo layout: start, primary, secondary, stop.
// - Reserved codes mark frame and line edges.
// - Real pixels equal to codes become four.
// - Binning by two repeats each pixel twice.
// - Binning by four repeats each pixel four times.
// - Data pins drive unless link powered down.
// - Clock pins drive only with both enabled.
// - Error pin stays low outside stereo mode.
// - Stereo streams out of step raise error.
// - Sequence 1023, 0, 1023 goes out as 1023, 4, 1023.
//
// Design decisions made here: the Avalon-MM interface to the registers and the register addresses.
`default_nettype none
module lvpps_serializer (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic pixValid,
  output logic pixReady,
  input wire logic [lvpps_pkg::PIX_W-1:0] primaryPixelBits,
  input wire logic lineFlag,
  input wire logic frameFlag,
  input wire logic secondaryValid,
  input wire logic [lvpps_pkg::PIX_W-1:0] secondaryPixelBits,
  input wire logic secondaryLineFlag,
  input wire logic secondaryFrameFlag,
  input wire logic linkClk,
  output logic serialDataPinsO,
  output logic serialDataPinsOe,
  output logic shiftClockPinsO,
  output logic shiftClockPinsOe,
  output logic stereoErrorPin,
  output logic irq
);
  import lvpps_pkg::*;

  logic [7:0] ctrl_q;
  logic [EV_W-1:0] irqStat_q;
  logic [EV_W-1:0] irqEn_q;
  logic waitReq_q;
  logic [31:0] rdData_q;
  logic irq_q;
  logic aValid_q;
  logic aLine_q;
  logic aFrame_q;
  logic [PIX_W-1:0] aPri_q;
  logic [PIX_W-1:0] aSec_q;
  logic bValid_q;
  logic bLine_q;
  logic bFrame_q;
  logic [PIX_W-1:0] bPri_q;
  logic [PIX_W-1:0] bSec_q;
  logic pLine_q;
  logic pFrame_q;
  logic pixReady_q;
  logic busy_q;
  logic [IDX_W-1:0] bitCnt_q;
  logic [IDX_W-1:0] lastIdx_q;
  logic [PKT_W-1:0] shReg_q;
  logic [1:0] repCnt_q;
  logic serOut_q;
  logic dataOe_q;
  logic clkOe_q;
  logic shClk_q;
  logic stereoErr_q;
  logic linkLvl;
  logic lkRise;
  logic [PKT_W-1:0] pkt;
  logic [IDX_W-1:0] pktLast;

  wire wide = ctrl_q[CTRL_WIDE];
  wire stereo = ctrl_q[CTRL_STEREO];
  wire [1:0] binSel = ctrl_q[CTRL_BIN +: 2];
  wire linkPd = ctrl_q[CTRL_LINKPD];
  wire clkPd = ctrl_q[CTRL_CLKPD];

  // Register slave answers one cycle after a request is seen.
  wire req = avs_read | avs_write;
  wire accept = req & waitReq_q;
  wire commit = avs_write & ~waitReq_q;
  wire selCtrl = avs_address == OFS_CTRL;
  wire selStat = avs_address == OFS_STATUS;
  wire selIrqStat = avs_address == OFS_IRQ_STAT;
  wire selIrqClr = avs_address == OFS_IRQ_CLR;
  wire selIrqEn = avs_address == OFS_IRQ_EN;
  wire wrCtrl = commit & selCtrl & avs_byteenable[0];
  wire wrClr = commit & selIrqClr & avs_byteenable[0];
  wire wrEn = commit & selIrqEn & avs_byteenable[0];
  wire [31:0] statWord = {27'h0, stereoErr_q, bValid_q, aValid_q,
    busy_q, linkLvl};
  wire [31:0] rdMux = selCtrl ? {24'h0, ctrl_q} :
    selStat ? statWord :
    selIrqStat ? {29'h0, irqStat_q} :
    selIrqEn ? {29'h0, irqEn_q} : 32'h0;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      waitReq_q <= 1'b1;
      rdData_q <= 32'h0;
    end else begin
      waitReq_q <= ~accept;
      if (accept) begin
        rdData_q <= rdMux;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_q <= CTRL_RESET;
      irqEn_q <= 3'h0;
    end else begin
      if (wrCtrl) begin
        ctrl_q <= avs_writedata[7:0];
      end
      if (wrEn) begin
        irqEn_q <= avs_writedata[EV_W-1:0];
      end
    end
  end

  // Shift clock sampled on the core clock.
  lvpps_edge_sync uSync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .asyncIn(linkClk),
    .level(linkLvl),
    .rise(lkRise)
  );

  // Two pixel stages: B is sent while A shows what comes next.
  wire take = pixValid & pixReady_q;
  wire lastBit = bitCnt_q == lastIdx_q;
  wire slotFree = ~busy_q | lastBit;
  wire loadNow = lkRise & slotFree & bValid_q & aValid_q;
  wire [1:0] repLast = (binSel == BIN_TWO) ? REP_TWO :
    (binSel == BIN_FOUR) ? REP_FOUR : REP_ONE;
  wire bDone = loadNow & (repCnt_q == repLast);
  wire moveAB = aValid_q & (~bValid_q | bDone);
  wire aValid_d = take | (aValid_q & ~moveAB);

  // Framing codes around frame and line edges.
  wire codeFe = pFrame_q & ~bFrame_q;
  wire codeLe = pLine_q & ~bLine_q;
  wire codeFs = ~bFrame_q & aFrame_q;
  wire codeLs = ~bLine_q & aLine_q;
  wire useCode = codeFe | codeLe | codeFs | codeLs;
  wire [PIX_W-1:0] codeVal = codeFe ? CODE_FE :
    codeLe ? CODE_LE : codeFs ? CODE_FS : CODE_LS;
  wire priLow = bPri_q < CODE_SUB;
  wire secLow = bSec_q < CODE_SUB;
  wire [PIX_W-1:0] txPri = useCode ? codeVal :
    (priLow ? CODE_SUB : bPri_q);
  wire [PIX_W-1:0] txSec = useCode ? codeVal :
    (secLow ? CODE_SUB : bSec_q);

  lvpps_packer uPack (
    .pri(txPri),
    .sec(txSec),
    .line(bLine_q),
    .frame(bFrame_q),
    .wide(wide),
    .stereo(stereo),
    .pkt(pkt),
    .lastIdx(pktLast)
  );

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      aValid_q <= 1'b0;
      aLine_q <= 1'b0;
      aFrame_q <= 1'b0;
      aPri_q <= 10'h000;
      aSec_q <= 10'h000;
      pixReady_q <= 1'b0;
    end else begin
      aValid_q <= aValid_d;
      pixReady_q <= ~aValid_d;
      if (take) begin
        aLine_q <= lineFlag;
        aFrame_q <= frameFlag;
        aPri_q <= primaryPixelBits;
        aSec_q <= secondaryPixelBits;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      bValid_q <= 1'b0;
      bLine_q <= 1'b0;
      bFrame_q <= 1'b0;
      bPri_q <= 10'h000;
      bSec_q <= 10'h000;
    end else if (moveAB) begin
      bValid_q <= 1'b1;
      bLine_q <= aLine_q;
      bFrame_q <= aFrame_q;
      bPri_q <= aPri_q;
      bSec_q <= aSec_q;
    end else if (bDone) begin
      bValid_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pLine_q <= 1'b0;
      pFrame_q <= 1'b0;
      repCnt_q <= 2'h0;
    end else if (loadNow) begin
      repCnt_q <= bDone ? 2'h0 : repCnt_q + 2'h1;
      if (bDone) begin
        pLine_q <= bLine_q;
        pFrame_q <= bFrame_q;
      end
    end
  end

  // One bit leaves on each rising shift clock edge.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      bitCnt_q <= 5'h00;
      lastIdx_q <= LAST_SINGLE;
      shReg_q <= 18'h00000;
      serOut_q <= 1'b0;
    end else if (lkRise & slotFree) begin
      busy_q <= loadNow;
      if (loadNow) begin
        shReg_q <= pkt;
        bitCnt_q <= 5'h00;
        lastIdx_q <= pktLast;
        serOut_q <= pkt[0];
      end else begin
        serOut_q <= 1'b0;
      end
    end else if (lkRise) begin
      shReg_q <= shReg_q >> 1;
      serOut_q <= shReg_q[1];
      bitCnt_q <= bitCnt_q + 5'h01;
    end
  end

  // Stereo streams must agree on every accepted beat.
  wire mismatch = take & (~secondaryValid |
    (secondaryLineFlag != lineFlag) |
    (secondaryFrameFlag != frameFlag));
  wire subEvent = loadNow & ~useCode & (priLow | (stereo & secLow));
  wire [EV_W-1:0] events = {subEvent, stereo & mismatch, loadNow};
  wire [EV_W-1:0] clrMask = wrClr ? avs_writedata[EV_W-1:0] : 3'h0;
  wire [EV_W-1:0] irqStat_d = events | (irqStat_q & ~clrMask);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irqStat_q <= 3'h0;
      irq_q <= 1'b0;
      stereoErr_q <= 1'b0;
    end else begin
      irqStat_q <= irqStat_d;
      irq_q <= |(irqStat_q & irqEn_q);
      stereoErr_q <= stereo & mismatch;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      dataOe_q <= 1'b0;
      clkOe_q <= 1'b0;
      shClk_q <= 1'b0;
    end else begin
      dataOe_q <= ~linkPd;
      clkOe_q <= ~linkPd & ~clkPd;
      shClk_q <= linkLvl;
    end
  end

  assign avs_readdata = rdData_q;
  assign avs_waitrequest = waitReq_q;
  assign pixReady = pixReady_q;
  assign serialDataPinsO = serOut_q;
  assign serialDataPinsOe = dataOe_q;
  assign shiftClockPinsO = shClk_q;
  assign shiftClockPinsOe = clkOe_q;
  assign stereoErrorPin = stereoErr_q;
  assign irq = irq_q;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_load;
    loadNow;
  endsequence

  sequence s_single_load;
    loadNow && !stereo;
  endsequence

  property p_single_len;
    s_single_load |=> lastIdx_q == 5'h0B && busy_q;
  endproperty
  a_single_len: assert property (p_single_len)
    else $error("single packet length wrong");

  property p_narrow_map;
    (s_single_load and !wide) |=> shReg_q[0] && !shReg_q[11] &&
      shReg_q[9] == $past(bLine_q) && shReg_q[10] == $past(bFrame_q) &&
      shReg_q[8:1] == $past(txPri[9:2]);
  endproperty
  a_narrow_map: assert property (p_narrow_map)
    else $error("eight bit packet layout wrong");

  property p_wide_map;
    (s_single_load and wide) |=> shReg_q[0] && !shReg_q[11] &&
      shReg_q[10:1] == $past(txPri);
  endproperty
  a_wide_map: assert property (p_wide_map)
    else $error("ten bit packet layout wrong");

  property p_stereo_map;
    (s_load and stereo) |=> lastIdx_q == 5'h11 && shReg_q[0] &&
      !shReg_q[17] && shReg_q[16:9] == $past(txSec[9:2]) &&
      shReg_q[8:1] == $past(txPri[9:2]);
  endproperty
  a_stereo_map: assert property (p_stereo_map)
    else $error("stereo packet layout wrong");

  property p_frame_code;
    (s_load and !pFrame_q && !bFrame_q && aFrame_q) |-> txPri == 10'h000;
  endproperty
  a_frame_code: assert property (p_frame_code)
    else $error("frame start code missing");

  property p_substitute;
    (s_load and !useCode && bPri_q < 10'h004) |-> txPri == 10'h004;
  endproperty
  a_substitute: assert property (p_substitute)
    else $error("reserved pixel value not replaced");

  property p_bin_two;
    bDone && binSel == 2'h1 |-> repCnt_q == 2'h1;
  endproperty
  a_bin_two: assert property (p_bin_two)
    else $error("bin two repeat count wrong");

  property p_bin_four;
    bDone && binSel == 2'h2 |-> repCnt_q == 2'h3;
  endproperty
  a_bin_four: assert property (p_bin_four)
    else $error("bin four repeat count wrong");

  property p_data_oe;
    ##1 serialDataPinsOe == !$past(linkPd);
  endproperty
  a_data_oe: assert property (p_data_oe)
    else $error("data pin enable wrong");

  property p_clk_oe;
    ##1 shiftClockPinsOe == ($past(!linkPd) && $past(!clkPd));
  endproperty
  a_clk_oe: assert property (p_clk_oe)
    else $error("clock pin enable wrong");

  property p_err_low;
    !stereo |=> !stereoErrorPin;
  endproperty
  a_err_low: assert property (p_err_low)
    else $error("error pin high outside stereo");

  property p_err_high;
    stereo && mismatch |=> stereoErrorPin;
  endproperty
  a_err_high: assert property (p_err_high)
    else $error("stereo mismatch not flagged");

  sequence s_shift;
    lkRise && busy_q && !lastBit;
  endsequence

  property p_shift_bit;
    s_shift |=> serialDataPinsO == $past(shReg_q[1]) &&
      bitCnt_q == $past(bitCnt_q) + 5'h01;
  endproperty
  a_shift_bit: assert property (p_shift_bit)
    else $error("shift order wrong");
endmodule
`default_nettype wire

// ==== pkg/lvpps_pkg.sv ====
// Constants shared by the pixel packet serializer.
`default_nettype none
package lvpps_pkg;
  localparam int PIX_W = 10;
  localparam int PKT_W = 18;
  localparam int IDX_W = 5;
  localparam int EV_W = 3;
  localparam logic [IDX_W-1:0] LAST_SINGLE = 5'h0B;
  localparam logic [IDX_W-1:0] LAST_STEREO = 5'h11;
  localparam logic [PIX_W-1:0] CODE_FS = 10'h000;
  localparam logic [PIX_W-1:0] CODE_LS = 10'h001;
  localparam logic [PIX_W-1:0] CODE_LE = 10'h002;
  localparam logic [PIX_W-1:0] CODE_FE = 10'h003;
  localparam logic [PIX_W-1:0] CODE_SUB = 10'h004;
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_STATUS = 5'h04;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h08;
  localparam logic [4:0] OFS_IRQ_CLR = 5'h0C;
  localparam logic [4:0] OFS_IRQ_EN = 5'h10;
  localparam int CTRL_WIDE = 0;
  localparam int CTRL_STEREO = 1;
  localparam int CTRL_BIN = 2;
  localparam int CTRL_LINKPD = 4;
  localparam int CTRL_DATAPD = 5;
  localparam int CTRL_CLKPD = 6;
  localparam logic [7:0] CTRL_RESET = 8'h70;
  localparam logic [1:0] BIN_TWO = 2'h1;
  localparam logic [1:0] BIN_FOUR = 2'h2;
  localparam logic [1:0] REP_ONE = 2'h0;
  localparam logic [1:0] REP_TWO = 2'h1;
  localparam logic [1:0] REP_FOUR = 2'h3;
  localparam int EV_PKT = 0;
  localparam int EV_SERR = 1;
  localparam int EV_SUB = 2;
endpackage
`default_nettype wire

// ==== testbench/lvpps_rx_model.sv ====
// Receive side model: deserializer with one-of-N pixel keeper.
`default_nettype none
module lvpps_rx_model (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic serialDataPinsO,
  input wire logic serialDataPinsOe,
  input wire logic shiftClockPinsO,
  input wire logic shiftClockPinsOe,
  input wire logic stereo,
  input wire logic [2:0] rep,
  output logic rawValid,
  output logic keepValid,
  output logic [17:0] pktRx,
  output logic lineRebuilt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic clkPrev;
  logic busy;
  logic fall;
  logic [4:0] cnt;
  logic [4:0] lastIdx;
  logic [2:0] keepCnt;
  logic [17:0] shiftQ;
  logic [17:0] full;
  assign fall = clkPrev && !shiftClockPinsO && shiftClockPinsOe
    && serialDataPinsOe;
  assign lastIdx = stereo ? 5'h11 : 5'h0B;
  assign full = shiftQ | (18'(serialDataPinsO) << cnt);
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      clkPrev <= 1'b0;
      busy <= 1'b0;
      cnt <= 5'h00;
      keepCnt <= 3'h0;
      shiftQ <= 18'h00000;
      pktRx <= 18'h00000;
      rawValid <= 1'b0;
      keepValid <= 1'b0;
      lineRebuilt <= 1'b0;
    end else begin
      clkPrev <= shiftClockPinsO;
      rawValid <= 1'b0;
      keepValid <= 1'b0;
      if (fall && !busy && serialDataPinsO) begin
        busy <= 1'b1;
        shiftQ <= 18'h00001;
        cnt <= 5'h01;
      end else if (fall && busy) begin
        shiftQ <= full;
        cnt <= cnt + 5'h01;
        if (cnt == lastIdx) begin
          busy <= 1'b0;
          pktRx <= full;
          rawValid <= 1'b1;
          keepValid <= (keepCnt == 3'h0);
          keepCnt <= (keepCnt + 3'h1 >= rep) ? 3'h0 : keepCnt + 3'h1;
          if (keepCnt == 3'h0 && full[10:1] == 10'h001) begin
            lineRebuilt <= 1'b1;
          end else if (keepCnt == 3'h0 && full[10:1] == 10'h002) begin
            lineRebuilt <= 1'b0;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/test_lvpps_serializer.sv ====
// Self-checking bench for the pixel packet serializer.
`default_nettype none
module test_lvpps_serializer;
  timeunit 1ns;
  timeprecision 1ps;
  import lvpps_pkg::*;
  logic core_clk;
  logic sys_rst;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic pixValid;
  logic pixReady;
  logic [PIX_W-1:0] primaryPixelBits;
  logic lineFlag;
  logic frameFlag;
  logic secondaryValid;
  logic [PIX_W-1:0] secondaryPixelBits;
  logic secondaryLineFlag;
  logic secondaryFrameFlag;
  logic linkClk;
  logic serialDataPinsO;
  logic serialDataPinsOe;
  logic shiftClockPinsO;
  logic shiftClockPinsOe;
  logic stereoErrorPin;
  logic irq;
  logic rawValid;
  logic [17:0] pktRx;
  logic [1:0] oeNow;
  logic curW;
  logic curSt;
  logic [2:0] curRep;
  logic [PIX_W-1:0] pq [0:127];
  logic [PIX_W-1:0] sq [0:127];
  logic lq [0:127];
  logic fq [0:127];
  logic [17:0] expQ [$];
  logic [17:0] rawQ [$];
  logic [31:0] d;
  int gi;
  int errExp;
  int errSeen;
  int numErrors;
  int cmpCount;
  assign oeNow = {serialDataPinsOe, shiftClockPinsOe};
  lvpps_serializer uut (
    .core_clk, .sys_rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .pixValid, .pixReady, .primaryPixelBits, .lineFlag, .frameFlag,
    .secondaryValid, .secondaryPixelBits, .secondaryLineFlag,
    .secondaryFrameFlag, .linkClk, .serialDataPinsO, .serialDataPinsOe,
    .shiftClockPinsO, .shiftClockPinsOe, .stereoErrorPin, .irq
  );
  lvpps_rx_model rx (
    .core_clk, .sys_rst, .serialDataPinsO, .serialDataPinsOe,
    .shiftClockPinsO, .shiftClockPinsOe, .stereo(curSt), .rep(curRep),
    .rawValid, .keepValid(), .pktRx, .lineRebuilt()
  );
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    linkClk = 1'b0;
    #3;
    forever #32 linkClk = ~linkClk;
  end
  always @(posedge core_clk) begin
    if (stereoErrorPin === 1'b1) errSeen++;
    if (rawValid === 1'b1) rawQ.push_back(pktRx);
  end
  function automatic logic [9:0] expPix(input int i, input logic [9:0] v);
    logic pl;
    logic pf;
    pl = (i > 0) ? lq[i - 1] : 1'b0;
    pf = (i > 0) ? fq[i - 1] : 1'b0;
    if (pf && !fq[i]) return CODE_FE;
    if (pl && !lq[i]) return CODE_LE;
    if (!fq[i] && fq[i + 1]) return CODE_FS;
    if (!lq[i] && lq[i + 1]) return CODE_LS;
    return (v < CODE_SUB) ? CODE_SUB : v;
  endfunction
  function automatic logic [17:0] expPkt(input int i);
    logic [9:0] p;
    logic [9:0] s;
    p = expPix(i, pq[i]);
    s = expPix(i, sq[i]);
    if (curSt) return {1'b0, s[9:2], p[9:2], 1'b1};
    if (curW) return {7'h00, p, 1'b1};
    return {7'h00, fq[i], lq[i], p[9:2], 1'b1};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      numErrors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("errors=%0d compares=%0d", numErrors, cmpCount);
    if (numErrors == 0 && cmpCount > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic busWrite(input logic [4:0] a, input logic [31:0] v);
    avs_address <= a;
    avs_writedata <= v;
    avs_write <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic busRead(input logic [4:0] a, output logic [31:0] v);
    avs_address <= a;
    avs_read <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    v = avs_readdata;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic sendBeat(input logic mis);
    pixValid <= 1'b1;
    primaryPixelBits <= pq[gi];
    lineFlag <= lq[gi];
    frameFlag <= fq[gi];
    secondaryValid <= 1'b1;
    secondaryPixelBits <= sq[gi];
    secondaryLineFlag <= lq[gi] ^ mis;
    secondaryFrameFlag <= fq[gi];
    do begin
      @(posedge core_clk);
    end while (pixReady !== 1'b1);
    if (gi > 0) repeat (curRep) expQ.push_back(expPkt(gi - 1));
    errExp += (mis && curSt) ? 1 : 0;
    gi++;
  endtask
  task automatic run(input logic w, st, input logic [1:0] bin, input int rep);
    busWrite(OFS_CTRL, {25'h0, 1'b0, w, 1'b0, bin, st, w});
    curW = w;
    curSt = st;
    curRep = 3'(rep);
    for (int i = 0; i < 16; i++) begin
      fq[gi] = (i >= 1 && i <= 13);
      lq[gi] = fq[gi] && i >= 2 && i <= 12 && i % 5 != 0;
      pq[gi] = 10'($urandom_range(0, 1023) >> ($urandom_range(0, 1) * 7));
      if (i >= 7 && i <= 9) pq[gi] = (i == 8) ? 10'h000 : 10'h3FF;
      sq[gi] = 10'($urandom_range(0, 1023) >> ($urandom_range(0, 1) * 7));
      sendBeat(i == 12);
    end
    pixValid <= 1'b0;
    for (int k = 0; k < 30000 && rawQ.size() < expQ.size(); k++) begin
      @(posedge core_clk);
    end
    repeat (300) @(posedge core_clk);
    check(32'(rawQ.size()), 32'(expQ.size()));
    foreach (rawQ[k]) check(32'(rawQ[k]), 32'(expQ[k]));
    check(32'(errSeen), 32'(errExp));
    rawQ.delete();
    expQ.delete();
  endtask
  initial begin
    #600000;
    numErrors++;
    summarize();
  end
  initial begin
    sys_rst = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    pixValid = 1'b0;
    primaryPixelBits = 10'h000;
    lineFlag = 1'b0;
    frameFlag = 1'b0;
    secondaryValid = 1'b0;
    secondaryPixelBits = 10'h000;
    secondaryLineFlag = 1'b0;
    secondaryFrameFlag = 1'b0;
    curW = 1'b0;
    curSt = 1'b0;
    curRep = 3'h1;
    gi = 0;
    errExp = 0;
    errSeen = 0;
    numErrors = 0;
    cmpCount = 0;
    void'($urandom(32'h8E0FDD41));
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    check(32'(oeNow), 32'h0);
    busRead(OFS_CTRL, d);
    check(d, {24'h0, CTRL_RESET});
    busWrite(5'h14, 32'hFFFFFFFF);
    busRead(5'h14, d);
    check(d, 32'h0);
    for (int k = 0; k < 8; k++) begin
      busWrite(OFS_CTRL, {25'h0, 3'(k), 4'h0});
      repeat (2) @(posedge core_clk);
      check(32'(oeNow), 32'({!k[0], !k[0] && !k[2]}));
    end
    run(1'b0, 1'b0, 2'h0, 1);
    run(1'b1, 1'b0, BIN_TWO, 2);
    run(1'b0, 1'b1, BIN_FOUR, 4);
    run(1'b1, 1'b0, BIN_FOUR, 4);
    run(1'b0, 1'b1, 2'h0, 1);
    busRead(OFS_IRQ_STAT, d);
    check(d & 32'h2, 32'h2);
    check(32'(irq), 32'h0);
    busWrite(OFS_IRQ_EN, 32'h2);
    repeat (2) @(posedge core_clk);
    check(32'(irq), 32'h1);
    busWrite(OFS_IRQ_CLR, 32'h7);
    repeat (2) @(posedge core_clk);
    check(32'(irq), 32'h0);
    busRead(OFS_IRQ_STAT, d);
    check(d, 32'h0);
    busWrite(OFS_CTRL, {24'h0, CTRL_RESET});
    repeat (2) @(posedge core_clk);
    check(32'(oeNow), 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
